// file: verilog/rpd_map.svh
`ifndef RPD_MAP_SVH
`define RPD_MAP_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define RPD_OFS_CTRL 8'h00
`define RPD_OFS_STATUS 8'h04
`define RPD_OFS_MASK 8'h08
`define RPD_OFS_PARAM0 8'h0C
`define RPD_OFS_PARAM1 8'h10
`define RPD_OFS_FLAGS 8'h14
`define RPD_OFS_BATT 8'h18
`define RPD_OFS_FIELD 8'h1C
`define RPD_OFS_DUTY 8'h20
`define RPD_OFS_SETPT 8'h24
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RPD_CTRL_RELOAD 0
`define RPD_CTRL_HOLD 1
`define RPD_IRQ_W 5
`define RPD_PARAM1_W 13
`define RPD_PARAM_RESET {13'h1200, 32'h05B2_700A}
// ****************************************************************
// Timing
// ****************************************************************
`define RPD_CLK_MHZ 100
`define RPD_SAMPLE_US 100
`define RPD_MS_US 1000
`define RPD_LAMP_BASE_MS 150
`define RPD_LAMP_STEP_MS 250
`define RPD_COEF_ONE 65536
`endif

// file: verilog/rpd_pkg.sv
package rpd_pkg;
   // Decoded parameter image, laid out as {word1[12:0], word0}
   typedef struct packed {
      logic ovshut_en;
      logic [3:0] rise_code;
      logic [7:0] setpoint_code;
      logic ramp_cur_en;
      logic ovc_en;
      logic thermal_en;
      logic amp_chk_dis;
      logic lamp_mode_en;
      logic low_field_en;
      logic uv_low_en;
      logic uv_full_en;
      logic ovlim_en;
      logic ov_en;
      logic uv_en;
      logic mech_mask;
      logic mech_dis;
      logic [2:0] lamp_flag_filter;
      logic [2:0] duty_cap;
      logic ifield_alt;
      logic [2:0] ifield_filt;
      logic [2:0] batt_filt2;
      logic [2:0] batt_filt1;
      logic [2:0] duty_filt;
   } rpd_param_t;
   // Diagnostic flags handed to the regulator core and serial link
   typedef struct packed {
      logic ov_prot;
      logic ov;
      logic uv_full;
      logic uv_low;
      logic low_field;
      logic lamp;
      logic thermal;
      logic ovc;
      logic ramp;
      logic field;
   } rpd_flags_t;
   typedef enum logic [2:0] {LD_REQ0, LD_WAIT0, LD_REQ1, LD_WAIT1, LD_DONE} rpd_load_t;
endpackage

// file: verilog/rpd_top.sv
// Behaviour
// - Duty monitor filter tau 13..106 ms by 3-bit code, default 40 ms.
// - Battery filter tau 0.8..6.7 ms by set-1 code while first gain set used.
// - Battery filter tau from set-2 code while second gain set used, default 0.8 ms.
// - Field filter tau 160/66/33/13 ms for codes 1..4, 66 ms above, 0 defers.
// - Field code 0: alternate bit picks 213 ms or 106 ms (default).
// - Phase regulation above battery limit caps duty by 3-bit code, 43%/50% top.
// - Phase overvoltage flag needs its enable and shutdown enable both set.
// - Low-voltage flag at 100% duty with phase below high threshold, default on.
// - Low-voltage flag below start speed with phase below threshold, default off.
// - Low field flag when duty above 40% and field current under 0.5 A.
// - Lamp-fault mode flags battery under 11.3 V below cut-off speed, default off.
// - Hot start allowed only if half peak-to-peak exceeds 3 V when checked.
// - Lamp flag filter 150 ms at code 0, else code quarter seconds.
// - Low-voltage flag enabled by default, plain overvoltage disabled by default.
// - Set-point 6-bit 10.6 V plus 100 mV steps, 0 off; 8-bit 25 mV, 16 V cap.
// - Rise time code plus one seconds; 4-bit tables reach at most 15 s.
// - Thermal and overcurrent flags each gated by own enable; ramp and field-current flags share the ramp enable.
`include "rpd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rpd_top #(
   parameter int SAMPLE_CYCLES = `RPD_SAMPLE_US * `RPD_CLK_MHZ,
   parameter int MS_CYCLES = `RPD_MS_US * `RPD_CLK_MHZ,
   parameter bit SETPOINT_WIDE = 1'b0,
   parameter int RISE_TABLE = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic nvm_rd_req,
   output logic nvm_rd_addr,
   input wire logic nvm_rd_valid,
   input wire logic [31:0] nvm_rd_data,
   input wire logic secondary_gain_set,
   input wire logic phase_reg_active,
   input wire logic batt_above_limit,
   input wire logic batt_overvolt,
   input wire logic phase_below_high,
   input wire logic speed_below_start,
   input wire logic speed_below_cutoff,
   input wire logic [15:0] phase_pp_mv,
   input wire logic [15:0] batt_mv,
   input wire logic [15:0] measured_field_current,
   input wire logic [15:0] duty_pm,
   input wire logic thermal_event,
   input wire logic overcurrent_event,
   input wire logic ramp_event,
   input wire logic field_event,
   output logic params_valid,
   output rpd_pkg::rpd_param_t params,
   output logic [15:0] batt_filt_mv,
   output logic [15:0] field_filt_ma,
   output logic [15:0] duty_filt_pm,
   output logic [15:0] duty_limit_pm,
   output logic [15:0] setpoint_mv,
   output logic [15:0] ramp_rise_ms,
   output rpd_pkg::rpd_flags_t flags,
   output logic hot_start_ok,
   output logic irq
);
   import rpd_pkg::*;

   // ****************************************************************
   // Coefficient helpers
   // ****************************************************************
   // Q16 coefficient Ts/tau; folded to a constant at each call site
   function automatic logic [16:0] coef(input int tau_us);
      return 17'((`RPD_SAMPLE_US * `RPD_COEF_ONE) / tau_us);
   endfunction

   function automatic logic [16:0] batt_coef(input logic [2:0] c);
      case (c)
         3'h0: return coef(800);
         3'h1: return coef(1700);
         3'h2: return coef(2500);
         3'h3: return coef(3300);
         3'h4: return coef(4200);
         3'h5: return coef(5000);
         3'h6: return coef(5800);
         default: return coef(6700);
      endcase
   endfunction

   // ****************************************************************
   // Parameter load from non-volatile storage
   // ****************************************************************
   rpd_load_t load_state;
   logic [31:0] word0;
   logic reload_req;
   logic filter_hold;

   // Two-word read; the image keeps its reset or last loaded value until both arrive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_state <= LD_REQ0;
         nvm_rd_req <= 1'b0;
         nvm_rd_addr <= 1'b0;
         word0 <= 32'h0000_0000;
         params <= `RPD_PARAM_RESET;
         params_valid <= 1'b0;
      end else begin
         nvm_rd_req <= 1'b0;
         case (load_state)
            LD_REQ0: begin
               nvm_rd_req <= 1'b1;
               nvm_rd_addr <= 1'b0;
               load_state <= LD_WAIT0;
            end
            LD_WAIT0: begin
               if (nvm_rd_valid) begin
                  word0 <= nvm_rd_data;
                  load_state <= LD_REQ1;
               end
            end
            LD_REQ1: begin
               nvm_rd_req <= 1'b1;
               nvm_rd_addr <= 1'b1;
               load_state <= LD_WAIT1;
            end
            LD_WAIT1: begin
               if (nvm_rd_valid) begin
                  params <= {nvm_rd_data[`RPD_PARAM1_W-1:0], word0};
                  params_valid <= 1'b1;
                  load_state <= LD_DONE;
               end
            end
            LD_DONE: begin
               // Reload drops valid so users never see a half-written image
               if (reload_req) begin
                  params_valid <= 1'b0;
                  load_state <= LD_REQ0;
               end
            end
            default: load_state <= LD_REQ0;
         endcase
      end
   end

   // ****************************************************************
   // Tick dividers
   // ****************************************************************
   logic [31:0] sample_cnt;
   logic [31:0] ms_cnt;
   logic sample_tick;
   logic ms_tick;

   // One-cycle enables for filter sampling and the millisecond base
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_cnt <= 32'h0000_0000;
         ms_cnt <= 32'h0000_0000;
         sample_tick <= 1'b0;
         ms_tick <= 1'b0;
      end else begin
         sample_tick <= (sample_cnt == 32'(SAMPLE_CYCLES - 1));
         ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
         sample_cnt <= (sample_cnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : sample_cnt + 32'h1;
         ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt + 32'h1;
      end
   end

   // ****************************************************************
   // Filter coefficients
   // ****************************************************************
   logic [16:0] coef_sel [3];

   // Battery tau follows the gain set in use; field code 0 defers
   always_comb begin
      coef_sel[0] = secondary_gain_set ? batt_coef(params.batt_filt2)
                                       : batt_coef(params.batt_filt1);
      case (params.ifield_filt)
         3'h0: coef_sel[1] = params.ifield_alt ? coef(106000) : coef(213000);
         3'h1: coef_sel[1] = coef(160000);
         3'h3: coef_sel[1] = coef(33000);
         3'h4: coef_sel[1] = coef(13000);
         default: coef_sel[1] = coef(66000);
      endcase
      case (params.duty_filt)
         3'h0: coef_sel[2] = coef(13000);
         3'h1: coef_sel[2] = coef(26000);
         3'h2: coef_sel[2] = coef(40000);
         3'h3: coef_sel[2] = coef(53000);
         3'h4: coef_sel[2] = coef(66000);
         3'h5: coef_sel[2] = coef(80000);
         3'h6: coef_sel[2] = coef(93000);
         default: coef_sel[2] = coef(106000);
      endcase
   end

   // ****************************************************************
   // First-order low-pass filters
   // ****************************************************************
   logic [15:0] filt_in [3];
   logic [31:0] filt_acc [3];

   assign filt_in[0] = batt_mv;
   assign filt_in[1] = measured_field_current;
   assign filt_in[2] = duty_pm;

   // y += (x - y) * Ts/tau in Q16; 16 fraction bits keep slow taus moving
   for (genvar i = 0; i < 3; i++) begin : g_filt
      logic signed [32:0] diff;
      logic signed [50:0] prod;
      assign diff = $signed({1'b0, filt_in[i], 16'h0000}) - $signed({1'b0, filt_acc[i]});
      assign prod = diff * $signed({1'b0, coef_sel[i]});
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            filt_acc[i] <= 32'h0000_0000;
         end else if (sample_tick && params_valid && !filter_hold) begin
            filt_acc[i] <= 32'($signed({1'b0, filt_acc[i]}) + prod[48:16]);
         end
      end
   end

   assign batt_filt_mv = filt_acc[0][31:16];
   assign field_filt_ma = filt_acc[1][31:16];
   assign duty_filt_pm = filt_acc[2][31:16];

   // ****************************************************************
   // Duty cap, set-point and ramp rise time
   // ****************************************************************
   logic [15:0] cap_pm;
   logic [15:0] rise_b2_ms;

   // Cap table in per-mille; the cap applies only in the limited case
   always_comb begin
      case (params.duty_cap)
         3'h0: cap_pm = 16'd55;
         3'h1: cap_pm = 16'd120;
         3'h2: cap_pm = 16'd180;
         3'h3: cap_pm = 16'd240;
         3'h4: cap_pm = 16'd310;
         3'h5: cap_pm = 16'd370;
         3'h6: cap_pm = 16'd430;
         default: cap_pm = 16'd500;
      endcase
      case (params.rise_code)
         4'h0: rise_b2_ms = 16'd0;
         4'h1: rise_b2_ms = 16'd250;
         4'h2: rise_b2_ms = 16'd500;
         4'h3: rise_b2_ms = 16'd750;
         4'hE: rise_b2_ms = 16'd12000;
         4'hF: rise_b2_ms = 16'd15000;
         default: rise_b2_ms = 16'((params.rise_code - 4'h3) * 1000);
      endcase
   end

   // Decoded working settings, registered for clean outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_limit_pm <= 16'd1000;
         setpoint_mv <= 16'h0000;
         ramp_rise_ms <= 16'h0000;
      end else begin
         duty_limit_pm <= (phase_reg_active && batt_above_limit) ? cap_pm : 16'd1000;
         if (!SETPOINT_WIDE) begin
            // Upper codes would run past the 16 V ceiling, so they saturate
            setpoint_mv <= (params.setpoint_code[5:0] == 6'h00) ? 16'h0000 :
               (params.setpoint_code[5:0] >= 6'h36) ? 16'd16000 :
               16'(10600 + 100 * params.setpoint_code[5:0]);
         end else begin
            setpoint_mv <= (params.setpoint_code >= 8'hD8) ? 16'd16000 :
               16'(10600 + 25 * params.setpoint_code);
         end
         case (RISE_TABLE)
            0: ramp_rise_ms <= 16'((params.rise_code[2:0] + 4'h1) * 1000);
            1: ramp_rise_ms <= 16'(params.rise_code * 1000);
            default: ramp_rise_ms <= rise_b2_ms;
         endcase
      end
   end

   // ****************************************************************
   // Diagnostic flags
   // ****************************************************************
   rpd_flags_t next_flags;
   logic lamp_cond;
   logic [15:0] lamp_ms;
   logic [15:0] lamp_limit_ms;

   // Conditions gated by their enables; nothing raised before load
   always_comb begin
      next_flags = '0;
      lamp_cond = params.lamp_mode_en && batt_filt_mv < 16'd11300 && speed_below_cutoff;
      lamp_limit_ms = (params.lamp_flag_filter == 3'h0) ? 16'(`RPD_LAMP_BASE_MS) :
         16'(params.lamp_flag_filter * `RPD_LAMP_STEP_MS);
      if (params_valid) begin
         next_flags.ov_prot = params.ovlim_en && params.ovshut_en &&
            phase_reg_active && batt_above_limit;
         next_flags.ov = params.ov_en && batt_overvolt;
         next_flags.uv_full = params.uv_en && params.uv_full_en &&
            duty_pm >= 16'd1000 && phase_below_high;
         next_flags.uv_low = params.uv_en && params.uv_low_en &&
            speed_below_start && phase_below_high;
         next_flags.low_field = params.low_field_en && duty_pm > 16'd400 &&
            field_filt_ma < 16'd500;
         next_flags.lamp = lamp_cond && lamp_ms >= lamp_limit_ms;
         next_flags.thermal = params.thermal_en && thermal_event;
         next_flags.ovc = params.ovc_en && overcurrent_event;
         next_flags.ramp = params.ramp_cur_en && ramp_event;
         next_flags.field = params.ramp_cur_en && field_event;
      end
   end

   // Lamp condition must persist for the filter time; any drop restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamp_ms <= 16'h0000;
      end else if (!lamp_cond || !params_valid) begin
         lamp_ms <= 16'h0000;
      end else if (ms_tick && lamp_ms != 16'hFFFF) begin
         lamp_ms <= lamp_ms + 16'h1;
      end
   end

   // Registered flags and hot-start permission
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
         hot_start_ok <= 1'b0;
      end else begin
         flags <= next_flags;
         hot_start_ok <= params_valid && (params.amp_chk_dis || phase_pp_mv > 16'd6000);
      end
   end

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   logic [`RPD_IRQ_W-1:0] irq_status;
   logic [`RPD_IRQ_W-1:0] irq_mask;
   logic [`RPD_IRQ_W-1:0] irq_set;
   logic [`RPD_IRQ_W-1:0] irq_clr;
   logic wr_en;
   logic load_done_evt;

   assign wr_en = psel && penable && pready && pwrite;
   assign load_done_evt = (load_state == LD_WAIT1) && nvm_rd_valid;
   assign irq_set = {(next_flags.ov_prot | next_flags.ov) & ~(flags.ov_prot | flags.ov),
                     next_flags.lamp & ~flags.lamp,
                     next_flags.low_field & ~flags.low_field,
                     (next_flags.uv_full | next_flags.uv_low) & ~(flags.uv_full | flags.uv_low),
                     load_done_evt};
   assign irq_clr = (wr_en && paddr == `RPD_OFS_STATUS) ? pwdata[`RPD_IRQ_W-1:0] : '0;

   // Write-one-to-clear; a new event in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   // Writable control bits; reload self-clears after one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
         filter_hold <= 1'b0;
         reload_req <= 1'b0;
      end else begin
         reload_req <= 1'b0;
         if (wr_en && paddr == `RPD_OFS_MASK) begin
            irq_mask <= pwdata[`RPD_IRQ_W-1:0];
         end
         if (wr_en && paddr == `RPD_OFS_CTRL) begin
            filter_hold <= pwdata[`RPD_CTRL_HOLD];
            reload_req <= pwdata[`RPD_CTRL_RELOAD];
         end
      end
   end

   // Answer prepared in the setup cycle, so access needs no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               `RPD_OFS_CTRL: prdata <= {30'h0, filter_hold, 1'b0};
               `RPD_OFS_STATUS: prdata <= 32'(irq_status);
               `RPD_OFS_MASK: prdata <= 32'(irq_mask);
               `RPD_OFS_PARAM0: prdata <= params[31:0];
               `RPD_OFS_PARAM1: prdata <= {18'h0, params_valid, params[44:32]};
               `RPD_OFS_FLAGS: prdata <= {21'h0, hot_start_ok, flags};
               `RPD_OFS_BATT: prdata <= {16'h0, batt_filt_mv};
               `RPD_OFS_FIELD: prdata <= {16'h0, field_filt_ma};
               `RPD_OFS_DUTY: prdata <= {16'h0, duty_filt_pm};
               `RPD_OFS_SETPT: prdata <= {ramp_rise_ms, setpoint_mv};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_duty_cap;
      @(posedge pclk) disable iff (!presetn)
      phase_reg_active && batt_above_limit && params.duty_cap == 3'h7 |=> duty_limit_pm == 16'd500;
   endproperty
   a_duty_cap: assert property (p_duty_cap) else $error("duty cap not 50 percent");

   property p_ov_prot;
      @(posedge pclk) disable iff (!presetn)
      flags.ov_prot |-> $past(params.ovlim_en && params.ovshut_en && batt_above_limit);
   endproperty
   a_ov_prot: assert property (p_ov_prot) else $error("ov protect flag without enables");

   property p_uv_full;
      @(posedge pclk) disable iff (!presetn)
      params_valid && params.uv_en && params.uv_full_en && duty_pm >= 16'd1000 &&
         phase_below_high |=> flags.uv_full;
   endproperty
   a_uv_full: assert property (p_uv_full) else $error("full duty low voltage missed");

   property p_uv_low;
      @(posedge pclk) disable iff (!presetn)
      flags.uv_low |-> $past(speed_below_start && phase_below_high && params.uv_low_en);
   endproperty
   a_uv_low: assert property (p_uv_low) else $error("low speed flag without cause");

   property p_low_field;
      @(posedge pclk) disable iff (!presetn)
      flags.low_field |-> $past(duty_pm > 16'd400 && field_filt_ma < 16'd500);
   endproperty
   a_low_field: assert property (p_low_field) else $error("low field flag without cause");

   property p_hot_start;
      @(posedge pclk) disable iff (!presetn)
      params_valid && !params.amp_chk_dis && phase_pp_mv <= 16'd6000 |=> !hot_start_ok;
   endproperty
   a_hot_start: assert property (p_hot_start) else $error("hot start on small amplitude");

   property p_setpoint_off;
      @(posedge pclk) disable iff (!presetn)
      !SETPOINT_WIDE && params.setpoint_code[5:0] == 6'h00 |=> setpoint_mv == 16'h0000;
   endproperty
   a_setpoint_off: assert property (p_setpoint_off) else $error("set-point not off");

   property p_load;
      @(posedge pclk) disable iff (!presetn)
      $rose(params_valid) |-> $past(load_state == LD_WAIT1 && nvm_rd_valid);
   endproperty
   a_load: assert property (p_load) else $error("valid without second word");

   property p_lamp;
      @(posedge pclk) disable iff (!presetn)
      $rose(flags.lamp) |-> $past(lamp_ms >= lamp_limit_ms && params.lamp_mode_en, 1);
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp flag before filter time");

   c_load: cover property (@(posedge pclk) disable iff (!presetn) $rose(params_valid));
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_lamp: cover property (@(posedge pclk) disable iff (!presetn) $rose(flags.lamp));
endmodule
`default_nettype wire

// file: verification/test_regulator_param_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "rpd_map.svh"
module test_regulator_param_decode;
   import rpd_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] nvm_rd_data = 32'h0;
   logic [31:0] prdata, rd, w0, w1;
   logic nvm_rd_valid = 1'b0;
   logic pra = 1'b0;
   logic bal = 1'b0;
   logic pbh = 1'b0;
   logic sbs = 1'b0;
   logic bov = 1'b0;
   logic sbc = 1'b0;
   logic [15:0] pp = 16'h0;
   logic [15:0] ifc = 16'h0;
   logic [15:0] duty = 16'h0;
   logic [3:0] ev = 4'h0;
   logic pready, pslverr, err, nvm_rd_req, nvm_rd_addr, params_valid, hot_start_ok, irq;
   logic [15:0] bf, ff, df, dl, sp, rr;
   rpd_param_t params;
   rpd_flags_t flags;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   int sp_code, rise, cap;
   // Short counts keep the filter and lamp timers inside a brief run
   rpd_top #(.SAMPLE_CYCLES(20), .MS_CYCLES(50)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_rd_req(nvm_rd_req),
      .nvm_rd_addr(nvm_rd_addr), .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data),
      .secondary_gain_set(1'b0), .phase_reg_active(pra), .batt_above_limit(bal),
      .batt_overvolt(bov), .phase_below_high(pbh), .speed_below_start(sbs),
      .speed_below_cutoff(sbc), .phase_pp_mv(pp), .batt_mv(16'h2710),
      .measured_field_current(ifc), .duty_pm(duty), .thermal_event(ev[3]),
      .overcurrent_event(ev[2]), .ramp_event(ev[1]), .field_event(ev[0]),
      .params_valid(params_valid), .params(params), .batt_filt_mv(bf), .field_filt_ma(ff),
      .duty_filt_pm(df), .duty_limit_pm(dl), .setpoint_mv(sp), .ramp_rise_ms(rr),
      .flags(flags), .hot_start_ok(hot_start_ok), .irq(irq));
   // ****************************************************************
   // Clock, storage responder and hang guard
   // ****************************************************************
   always #5 pclk = ~pclk;
   // Storage answers one cycle after a request; data is scrambled between answers
   always @(posedge pclk) begin
      nvm_rd_valid <= nvm_rd_req;
      nvm_rd_data <= nvm_rd_req ? (nvm_rd_addr ? w1 : w0) : ~nvm_rd_data;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 10000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic conclude;
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Holds the request until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'hE9B3));
      w0 = 32'h05B2700A;
      w0[31:29] = 3'($urandom_range(7, 0));
      w0[25] = 1'($urandom_range(1, 0));
      w0[22] = 1'($urandom_range(1, 0));
      // Lamp mode on with the shortest filter time keeps the lamp test brief
      w0[27] = 1'b1;
      w0[18:16] = 3'h0;
      cap = 6 + $urandom_range(1, 0);
      w0[15:13] = 3'(cap);
      sp_code = $urandom_range(63, 1);
      rise = $urandom_range(7, 0);
      w1 = {19'h0, 1'b1, 4'(rise), 8'(sp_code)};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      while (params_valid !== 1'b1) @(posedge pclk);
      apb(1'b0, `RPD_OFS_PARAM0, 32'h0);
      check(rd, w0);
      apb(1'b0, `RPD_OFS_PARAM1, 32'h0);
      check(rd, {18'h0, 1'b1, w1[12:0]});
      apb(1'b0, `RPD_OFS_STATUS, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, `RPD_OFS_SETPT, 32'h0);
      check(32'(rd[15:0]), (sp_code >= 54) ? 32'd16000 : 32'(10600 + 100 * sp_code));
      check(32'(rd[31:16]), 32'((rise + 1) * 1000));
      apb(1'b0, 8'hFC, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, `RPD_OFS_MASK, 32'h4);
      check(32'(dl), 32'd1000);
      // Just outside the duty and amplitude thresholds; enabled level flags follow
      @(posedge pclk);
      pra <= 1'b1;
      bal <= 1'b1;
      ifc <= 16'd500;
      duty <= 16'd400;
      pbh <= 1'b1;
      pp <= 16'd6000;
      ev <= 4'hF;
      sbs <= 1'b1;
      bov <= 1'b1;
      step(4);
      check(32'(dl), (cap == 6) ? 32'd430 : 32'd500);
      check(32'(flags.low_field), 32'h0);
      check(32'(flags.uv_full), 32'h0);
      check(32'(hot_start_ok), 32'h0);
      check(32'(irq), 32'h0);
      check(32'(flags[3:0]), 32'({w0[29], w0[30], w0[31], w0[31]}));
      check(32'(flags.uv_low), 32'(w0[25]));
      check(32'(flags.ov), 32'(w0[22]));
      check(32'(flags.ov_prot), 32'h1);
      check(32'(flags.lamp), 32'h0);
      // One below full duty: low field rises, full-duty flag not yet
      @(posedge pclk);
      ifc <= 16'd499;
      duty <= 16'd999;
      pp <= 16'd6001;
      step(4);
      check(32'(flags.low_field), 32'h1);
      check(32'(flags.uv_full), 32'h0);
      check(32'(hot_start_ok), 32'h1);
      check(32'(irq), 32'h1);
      @(posedge pclk);
      duty <= 16'd1000;
      step(4);
      check(32'(flags.uv_full), 32'h1);
      apb(1'b1, `RPD_OFS_STATUS, 32'h4);
      step(2);
      check(32'(irq), 32'h0);
      // Lamp condition must persist 150 millisecond ticks before the flag shows
      @(posedge pclk);
      sbc <= 1'b1;
      step(7449);
      check(32'(flags.lamp), 32'h0);
      step(53);
      check(32'(flags.lamp), 32'h1);
      check(32'(bf > 16'd9990 && bf <= 16'd10000), 32'h1);
      // Reload drops valid, then the same image comes back from storage
      apb(1'b1, `RPD_OFS_CTRL, 32'h1);
      step(1);
      check(32'(params_valid), 32'h0);
      while (params_valid !== 1'b1) @(posedge pclk);
      apb(1'b0, `RPD_OFS_PARAM0, 32'h0);
      check(rd, w0);
      conclude();
   end
endmodule
`default_nettype wire
